// >>> shared/buck_ctrl_pkg.sv
/*
 * Constants and types shared by the buck current and mode control
 * register and its write-release tracker.
 * Assumes a frame engine that delivers whole, decoded SPI frames.
 */
package buck_ctrl_pkg;

	// Frame geometry.
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;

	// Register addresses within the control space.
	localparam logic [5:0] RELEASE_REG_ADDR = 6'h01;
	localparam logic [5:0] BUCK_CTRL_ADDR   = 6'h02;

	// Field positions in the buck current and mode control word.
	localparam int CH1_PEAK_LSB = 18;
	localparam int CH2_PEAK_LSB = 12;
	localparam int CH1_VT_LSB   = 8;
	localparam int CH2_VT_LSB   = 4;
	localparam int STANDBY_BIT  = 3;
	localparam int ACTIVE_BIT   = 2;
	localparam int RESERVED_BIT = 1;
	localparam int PARITY_BIT   = 0;

	// Position of the write-release bit in its own register.
	localparam int RELEASE_BIT = 1;

	// Values after reset of the fields not taken from trim.
	localparam logic [5:0] CH2_PEAK_RST = 6'h20;
	localparam logic [3:0] CH2_VT_RST   = 4'hf;
	localparam logic       STANDBY_RST  = 1'h0;
	localparam logic       ACTIVE_RST   = 1'h0;
	localparam logic       RESERVED_RST = 1'h0;

	// Values that stand in trim fields until trim has been captured.
	localparam logic [5:0] CH1_PEAK_PRE = 6'h00;
	localparam logic [3:0] CH1_VT_PRE   = 4'h0;

	// Operating mode as chosen by the two lock-protected bits.
	typedef enum logic [1:0] {
		mode_limp,
		mode_active,
		mode_standby
	} op_mode_t;

endpackage

// >>> core/write_release_tracker.sv
/*
 * Tracks the one-shot write-release grant held in the release register.
 * Assumes frames arrive already parity-checked, one strobe per frame.
 */
`timescale 1ns/100ps
module write_release_tracker
	import buck_ctrl_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       frame_ok,
	input  wire logic                       frame_write,
	input  wire logic [buck_ctrl_pkg::ADDR_W-1:0] frame_addr,
	input  wire logic [buck_ctrl_pkg::DATA_W-1:0] frame_data,
	output logic                            release_now
);
	import buck_ctrl_pkg::*;

	typedef struct packed {
		logic granted;
	} rel_state_t;

	rel_state_t s_q;
	rel_state_t s_d;

	// Any valid frame ends the grant; only an unlock write starts a new
	// one, so the grant covers exactly the following frame.
	always_comb
	begin
		s_d = s_q;
		if (frame_ok)
		begin
			s_d.granted = frame_write && (frame_addr == RELEASE_REG_ADDR)
				&& frame_data[RELEASE_BIT];
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s_q <= '{granted: 1'b0};
		else if (ce)
			s_q <= s_d;
	end

	assign release_now = s_q.granted;

endmodule

// >>> core/buck_mode_control_register.sv
/*
 * Buck current and mode control register: peak current and VLED x TOFF
 * selections for both channels, lock-protected standby and active bits,
 * the reserved bit, odd parity checking and the operating mode.
 * Assumes a frame engine that presents each decoded SPI frame for one
 * clock on frame_strobe, and trim values that are stable at reset.
 */
// Notes on behaviour
// - Channel one peak current, six bits, from trim.
// - Channel two peak current, six bits, reset 100000.
// - Channel one volt-offtime code, four bits, from trim.
// - Channel two volt-offtime code, reset 1111.
// - Bit three requests standby unless active set.
// - Setting standby needs the write-release grant.
// - Clearing standby is always accepted.
// - Bit two selects active mode versus limp-home.
// - Wake-up event clears active, giving limp-home unless standby set.
// - Setting active needs the write-release grant.
// - Clearing active is always accepted.
// - Frame bit zero carries odd parity, checked here.
// - Write-release grant lapses after the next valid frame.
`timescale 1ns/100ps
module buck_mode_control_register
	import buck_ctrl_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       frame_strobe,
	input  wire logic                       frame_write,
	input  wire logic [buck_ctrl_pkg::ADDR_W-1:0] frame_addr,
	input  wire logic [buck_ctrl_pkg::DATA_W-1:0] frame_data,
	input  wire logic                       wake_event,
	input  wire logic [5:0]                 otp_ch1_peak,
	input  wire logic [3:0]                 otp_ch1_volt_offtime,
	output logic [5:0]                      ch1_inductor_peak_sel,
	output logic [5:0]                      ch2_inductor_peak_sel,
	output logic [3:0]                      ch1_volt_offtime_sel,
	output logic [3:0]                      ch2_volt_offtime_sel,
	output logic                            standby_request,
	output logic                            active_enable,
	output logic                            reserved_bit,
	output buck_ctrl_pkg::op_mode_t         op_mode,
	output logic                            write_release,
	output logic [buck_ctrl_pkg::DATA_W-1:0] read_data,
	output logic                            read_valid,
	output logic                            parity_error
);
	import buck_ctrl_pkg::*;

	typedef struct packed {
		logic [5:0]          ch1_peak;
		logic [5:0]          ch2_peak;
		logic [3:0]          ch1_vt;
		logic [3:0]          ch2_vt;
		logic                stby;
		logic                act;
		logic                rsv;
		logic                trim_done;
		op_mode_t            mode;
		logic [DATA_W-1:0]   rdata;
		logic                rvalid;
		logic                perr;
	} reg_state_t;

	localparam reg_state_t STATE_RST = '{
		ch1_peak:  CH1_PEAK_PRE,
		ch2_peak:  CH2_PEAK_RST,
		ch1_vt:    CH1_VT_PRE,
		ch2_vt:    CH2_VT_RST,
		stby:      STANDBY_RST,
		act:       ACTIVE_RST,
		rsv:       RESERVED_RST,
		trim_done: 1'b0,
		mode:      mode_limp,
		rdata:     '0,
		rvalid:    1'b0,
		perr:      1'b0
	};

	reg_state_t s_q;
	reg_state_t s_d;

	logic       parity_ok;
	logic       frame_ok;
	logic       write_hit;
	logic       read_hit;
	logic       release_now;
	logic [DATA_W-1:0] word_now;

	// Odd parity over the whole data word, parity bit included.
	assign parity_ok = ^frame_data;
	assign frame_ok  = frame_strobe && parity_ok;
	assign write_hit = frame_ok && frame_write
		&& (frame_addr == BUCK_CTRL_ADDR);
	assign read_hit  = frame_ok && !frame_write
		&& (frame_addr == BUCK_CTRL_ADDR);

	// The grant tracker sees the same validated frames, so its grant is
	// still the old one while this register acts on the frame.
	write_release_tracker u_release (
		.clock       (clock),
		.rst         (rst),
		.ce          (ce),
		.frame_ok    (frame_ok),
		.frame_write (frame_write),
		.frame_addr  (frame_addr),
		.frame_data  (frame_data),
		.release_now (release_now)
	);

	// Readback image; bit zero is regenerated so the word has odd parity.
	always_comb
	begin
		word_now = '0;
		word_now[CH1_PEAK_LSB +: 6] = s_q.ch1_peak;
		word_now[CH2_PEAK_LSB +: 6] = s_q.ch2_peak;
		word_now[CH1_VT_LSB +: 4]   = s_q.ch1_vt;
		word_now[CH2_VT_LSB +: 4]   = s_q.ch2_vt;
		word_now[STANDBY_BIT]       = s_q.stby;
		word_now[ACTIVE_BIT]        = s_q.act;
		word_now[RESERVED_BIT]      = s_q.rsv;
		word_now[PARITY_BIT]        = ~(^word_now[DATA_W-1:1]);
	end

	// Next state. Trim is captured once after reset release; a write in
	// that same cycle wins, since software spoke last.
	always_comb
	begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		s_d.perr   = frame_strobe && !parity_ok;
		if (!s_q.trim_done)
		begin
			s_d.trim_done = 1'b1;
			s_d.ch1_peak  = otp_ch1_peak;
			s_d.ch1_vt    = otp_ch1_volt_offtime;
		end
		if (write_hit)
		begin
			s_d.ch1_peak = frame_data[CH1_PEAK_LSB +: 6];
			s_d.ch2_peak = frame_data[CH2_PEAK_LSB +: 6];
			s_d.ch1_vt   = frame_data[CH1_VT_LSB +: 4];
			s_d.ch2_vt   = frame_data[CH2_VT_LSB +: 4];
			// The host is expected to write one here; the bit simply
			// stores what arrives so a careless host can be spotted.
			s_d.rsv      = frame_data[RESERVED_BIT];
			if (!frame_data[STANDBY_BIT])
				s_d.stby = 1'b0;
			else if (release_now)
				s_d.stby = 1'b1;
			if (!frame_data[ACTIVE_BIT])
				s_d.act = 1'b0;
			else if (release_now)
				s_d.act = 1'b1;
		end
		// A wake-up always clears active, even against a write.
		if (wake_event)
			s_d.act = 1'b0;
		if (read_hit)
		begin
			s_d.rdata  = word_now;
			s_d.rvalid = 1'b1;
		end
		// Mode follows the stored bits one cycle later.
		case ({s_q.stby, s_q.act})
			2'b10:   s_d.mode = mode_standby;
			2'b01:   s_d.mode = mode_active;
			2'b00:   s_d.mode = mode_limp;
			2'b11:   s_d.mode = s_q.mode;
			default: s_d.mode = mode_limp;
		endcase
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s_q <= STATE_RST;
		else if (ce)
			s_q <= s_d;
	end

	// Outputs straight from state.
	assign ch1_inductor_peak_sel = s_q.ch1_peak;
	assign ch2_inductor_peak_sel = s_q.ch2_peak;
	assign ch1_volt_offtime_sel  = s_q.ch1_vt;
	assign ch2_volt_offtime_sel  = s_q.ch2_vt;
	assign standby_request       = s_q.stby;
	assign active_enable         = s_q.act;
	assign reserved_bit          = s_q.rsv;
	assign op_mode               = s_q.mode;
	assign write_release         = release_now;
	assign read_data             = s_q.rdata;
	assign read_valid            = s_q.rvalid;
	assign parity_error          = s_q.perr;

	// Checks on the documented behaviour.
	property p_stby_locked;
		@(posedge clock) disable iff (rst)
		ce && write_hit && frame_data[STANDBY_BIT] && !release_now
		|=> standby_request == $past(standby_request);
	endproperty
	a_stby_locked: assert property (p_stby_locked)
		else $error("Standby set without write release.");

	property p_stby_set;
		@(posedge clock) disable iff (rst)
		ce && write_hit && frame_data[STANDBY_BIT] && release_now
		|=> standby_request && !write_release;
	endproperty
	a_stby_set: assert property (p_stby_set)
		else $error("Released standby write not taken.");

	property p_stby_clear;
		@(posedge clock) disable iff (rst)
		ce && write_hit && !frame_data[STANDBY_BIT] |=> !standby_request;
	endproperty
	a_stby_clear: assert property (p_stby_clear)
		else $error("Standby clear refused.");

	property p_act_locked;
		@(posedge clock) disable iff (rst)
		ce && write_hit && frame_data[ACTIVE_BIT] && !release_now
		&& !wake_event
		|=> active_enable == $past(active_enable);
	endproperty
	a_act_locked: assert property (p_act_locked)
		else $error("Active set without write release.");

	property p_act_clear;
		@(posedge clock) disable iff (rst)
		ce && (wake_event || (write_hit && !frame_data[ACTIVE_BIT]))
		|=> !active_enable;
	endproperty
	a_act_clear: assert property (p_act_clear)
		else $error("Active clear or wake-up not taken.");

	property p_mode_standby;
		@(posedge clock) disable iff (rst)
		ce && standby_request && !active_enable
		|=> op_mode == mode_standby;
	endproperty
	a_mode_standby: assert property (p_mode_standby)
		else $error("Standby mode not entered.");

	property p_mode_active;
		@(posedge clock) disable iff (rst)
		ce && !standby_request && active_enable
		|=> op_mode == mode_active;
	endproperty
	a_mode_active: assert property (p_mode_active)
		else $error("Active mode not entered.");

	property p_mode_hold;
		@(posedge clock) disable iff (rst)
		ce && standby_request && active_enable |=> $stable(op_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("Mode changed with both bits set.");

	property p_bad_parity;
		@(posedge clock) disable iff (rst)
		ce && frame_strobe && !parity_ok && s_q.trim_done
		|=> parity_error && $stable(ch2_inductor_peak_sel)
		&& $stable(ch2_volt_offtime_sel) && $stable(write_release);
	endproperty
	a_bad_parity: assert property (p_bad_parity)
		else $error("Bad-parity frame was not ignored.");

	property p_fields;
		@(posedge clock) disable iff (rst)
		ce && write_hit
		|=> ch2_inductor_peak_sel == $past(frame_data[17:12])
		&& ch2_volt_offtime_sel == $past(frame_data[7:4])
		&& ch1_inductor_peak_sel == $past(frame_data[23:18]);
	endproperty
	a_fields: assert property (p_fields)
		else $error("Selection fields not stored.");

	property p_trim;
		@(posedge clock) disable iff (rst)
		ce && !s_q.trim_done && !write_hit
		|=> ch1_inductor_peak_sel == $past(otp_ch1_peak)
		&& ch1_volt_offtime_sel == $past(otp_ch1_volt_offtime);
	endproperty
	a_trim: assert property (p_trim)
		else $error("Trim defaults not captured.");

	property p_release_once;
		@(posedge clock) disable iff (rst)
		ce && frame_ok && write_release
		&& !(frame_write && frame_addr == RELEASE_REG_ADDR
		&& frame_data[RELEASE_BIT])
		|=> !write_release;
	endproperty
	a_release_once: assert property (p_release_once)
		else $error("Write release outlived next frame.");

	property p_read_parity;
		@(posedge clock) disable iff (rst)
		read_valid |-> ^read_data;
	endproperty
	a_read_parity: assert property (p_read_parity)
		else $error("Readback word lacks odd parity.");

endmodule

// >>> test/spi_host_model.sv
/*
 * Behavioural SPI host that hands whole decoded frames to the register.
 * Assumes its tasks are called from the bench between clock edges.
 */
`timescale 1ns/100ps
module spi_host_model
	import buck_ctrl_pkg::*;
(
	input  wire logic                         clock,
	output logic                              frame_strobe,
	output logic                              frame_write,
	output logic [buck_ctrl_pkg::ADDR_W-1:0]  frame_addr,
	output logic [buck_ctrl_pkg::DATA_W-1:0]  frame_data
);
	// Lines start idle; released lines later show the inverse word.
	initial
	begin
		frame_strobe = 1'b0;
		frame_write = 1'b0;
		frame_addr = 6'h00;
		frame_data = 24'h000000;
	end

	// One frame for one clock; bad inverts the parity bit on purpose.
	task automatic send(input logic w, input logic [5:0] a,
		input logic [22:0] d, input logic bad);
		@(posedge clock);
		frame_strobe <= 1'b1;
		frame_write <= w;
		frame_addr <= a;
		frame_data <= {d, ~^d ^ bad};
		@(posedge clock);
		frame_strobe <= 1'b0;
		frame_write <= ~w;
		frame_addr <= ~a;
		frame_data <= ~{d, ~^d ^ bad};
	endtask

	// Optional unlock, then the control word with reserved bit at one.
	task automatic write_ctrl(input logic rel, input logic [19:0] f,
		input logic s, input logic e, input logic bad);
		if (rel)
			send(1'b1, RELEASE_REG_ADDR, 23'h000001, 1'b0);
		send(1'b1, BUCK_CTRL_ADDR, {f, s, e, 1'b1}, bad);
	endtask
endmodule

// >>> test/test_buck_mode_control_register.sv
/*
 * Self-checking bench for the buck current and mode control register.
 * Assumes spi_host_model drives the frame port at a 40 MHz clock.
 */
`timescale 1ns/100ps
module test_buck_mode_control_register;
	import buck_ctrl_pkg::*;
	localparam logic [5:0]  OTP_P = 6'h2d;
	localparam logic [3:0]  OTP_V = 4'h9;
	localparam logic [19:0] F     = 20'h44536;
	logic        clock, rst, ce, wake_event, sb, ae, rb, wrel, rv, pe;
	logic        fs, fw;
	logic [5:0]  p1, p2, fa;
	logic [3:0]  v1, v2;
	logic [23:0] rd, fd;
	op_mode_t    om;
	int          err_count, checks;

	spi_host_model i_host (.clock(clock), .frame_strobe(fs),
		.frame_write(fw), .frame_addr(fa), .frame_data(fd));

	buck_mode_control_register i_dut (.clock(clock), .rst(rst), .ce(ce),
		.frame_strobe(fs), .frame_write(fw), .frame_addr(fa),
		.frame_data(fd), .wake_event(wake_event), .otp_ch1_peak(OTP_P),
		.otp_ch1_volt_offtime(OTP_V), .ch1_inductor_peak_sel(p1),
		.ch2_inductor_peak_sel(p2), .ch1_volt_offtime_sel(v1),
		.ch2_volt_offtime_sel(v2), .standby_request(sb),
		.active_enable(ae), .reserved_bit(rb), .op_mode(om),
		.write_release(wrel), .read_data(rd), .read_valid(rv),
		.parity_error(pe));

	// Free-running 40 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic chk(input string n, input logic [23:0] e, g);
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			err_count++;
		end
		checks++;
	endtask

	// Settles past the edge, then compares every field but the reserved bit.
	task automatic chk_img(input logic [19:0] f, input logic s, e);
		#1;
		chk("ch1_peak", 24'(f[19:14]), 24'(p1));
		chk("ch2_peak", 24'(f[13:8]), 24'(p2));
		chk("ch1_vt", 24'(f[7:4]), 24'(v1));
		chk("ch2_vt", 24'(f[3:0]), 24'(v2));
		chk("standby", 24'(s), 24'(sb));
		chk("active", 24'(e), 24'(ae));
	endtask

	// The mode lags the bits by one further clock.
	task automatic chk_mode(input op_mode_t m);
		@(posedge clock);
		#1;
		chk("op_mode", 24'(m), 24'(om));
	endtask

	task automatic t_reset();
		chk_img({OTP_P, 6'h20, OTP_V, 4'hf}, 1'b0, 1'b0);
		chk("reserved", 24'h0, 24'(rb));
		chk("op_mode", 24'(mode_limp), 24'(om));
		$display("t_reset done");
	endtask

	task automatic t_locked();
		i_host.write_ctrl(1'b0, F, 1'b1, 1'b1, 1'b0);
		chk_img(F, 1'b0, 1'b0);
		chk("reserved", 24'h1, 24'(rb));
		$display("t_locked done");
	endtask

	task automatic t_active();
		i_host.write_ctrl(1'b1, F, 1'b0, 1'b1, 1'b0);
		chk_img(F, 1'b0, 1'b1);
		chk("grant", 24'h0, 24'(wrel));
		chk_mode(mode_active);
		i_host.write_ctrl(1'b0, F, 1'b0, 1'b0, 1'b0);
		chk_img(F, 1'b0, 1'b0);
		chk_mode(mode_limp);
		$display("t_active done");
	endtask

	task automatic t_standby();
		i_host.write_ctrl(1'b1, F, 1'b1, 1'b0, 1'b0);
		chk_img(F, 1'b1, 1'b0);
		chk_mode(mode_standby);
		i_host.write_ctrl(1'b0, F, 1'b0, 1'b0, 1'b0);
		chk_img(F, 1'b0, 1'b0);
		chk_mode(mode_limp);
		$display("t_standby done");
	endtask

	// A read between unlock and write uses up the grant; the read
	// strobe lasts one cycle while the data stays until the next read.
	task automatic t_lapse();
		i_host.send(1'b1, RELEASE_REG_ADDR, 23'h000001, 1'b0);
		#1;
		chk("grant", 24'h1, 24'(wrel));
		i_host.send(1'b0, BUCK_CTRL_ADDR, 23'h000000, 1'b0);
		#1;
		chk("read_valid", 24'h1, 24'(rv));
		chk("read_data", {F, 3'h1, ~^{F, 3'h1}}, rd);
		@(posedge clock);
		#1;
		chk("read_valid", 24'h0, 24'(rv));
		chk("read_data", {F, 3'h1, ~^{F, 3'h1}}, rd);
		chk("grant", 24'h0, 24'(wrel));
		i_host.write_ctrl(1'b0, F, 1'b0, 1'b1, 1'b0);
		chk_img(F, 1'b0, 1'b0);
		$display("t_lapse done");
	endtask

	// A bad frame is dropped whole and leaves the grant standing.
	task automatic t_parity();
		i_host.send(1'b1, RELEASE_REG_ADDR, 23'h000001, 1'b0);
		i_host.write_ctrl(1'b0, ~F, 1'b1, 1'b0, 1'b1);
		#1;
		chk("parity_error", 24'h1, 24'(pe));
		chk_img(F, 1'b0, 1'b0);
		i_host.write_ctrl(1'b0, F, 1'b0, 1'b1, 1'b0);
		chk_img(F, 1'b0, 1'b1);
		chk("parity_error", 24'h0, 24'(pe));
		$display("t_parity done");
	endtask

	task automatic t_wake();
		@(posedge clock);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
		chk_img(F, 1'b0, 1'b0);
		chk_mode(mode_limp);
		$display("t_wake done");
	endtask

	task automatic t_both();
		i_host.write_ctrl(1'b1, F, 1'b0, 1'b1, 1'b0);
		i_host.write_ctrl(1'b1, F, 1'b1, 1'b1, 1'b0);
		chk_img(F, 1'b1, 1'b1);
		chk_mode(mode_active);
		$display("t_both done");
	endtask

	// Frames sent while the clock enable is low must leave no trace,
	// not even a write-release grant.
	task automatic t_freeze();
		@(posedge clock);
		ce <= 1'b0;
		i_host.write_ctrl(1'b1, ~F, 1'b0, 1'b0, 1'b0);
		chk_img(F, 1'b1, 1'b1);
		chk("grant", 24'h0, 24'(wrel));
		chk_mode(mode_active);
		@(posedge clock);
		ce <= 1'b1;
		i_host.write_ctrl(1'b0, F, 1'b0, 1'b0, 1'b0);
		chk_img(F, 1'b0, 1'b0);
		$display("t_freeze done");
	endtask

	task automatic conclude();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence after 16 clocks of reset.
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		wake_event = 1'b0;
		err_count = 0;
		checks = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		t_reset();
		t_locked();
		t_active();
		t_standby();
		t_lapse();
		t_parity();
		t_wake();
		t_both();
		t_freeze();
		conclude();
	end

	// The run needs about 70 clocks; this limit is far above.
	initial
	begin
		#(25 * 5000);
		err_count++;
		conclude();
	end
endmodule
